//--- design/rar_alias_remap.sv
// Function
// [R1] Physical slots hold a 7-bit remote target address in bits 7:1.
// [R2] A local request hitting an alias is forwarded with the physical address instead.
// [R3] Alias slots hold a 7-bit alias in bits 7:1 used by the address decoder.
// [R4] Alias slot N remaps to physical slot N of the same index.
// [R5] A zero alias disables its slot: no detection, no forwarding.
// [R6] Each nonzero alias arms its own slot independently of the others.
// [R7] A request matching no enabled alias is neither remapped nor forwarded.
`timescale 1ns/1ns
`default_nettype none
`include "rar_defs.svh"

module rar_alias_remap
    import rar_pkg::*;
(
    // Clock and reset
    input  wire logic                 REF_CLK_I,
    input  wire logic                 RST_I,
    // APB slave
    input  wire logic                 PSEL_I,
    input  wire logic                 PENABLE_I,
    input  wire logic                 PWRITE_I,
    input  wire rar_pkg::rar_paddr_t  PADDR_I,
    input  wire rar_pkg::rar_word_t   PWDATA_I,
    output logic                      PREADY_O,
    output rar_pkg::rar_word_t        PRDATA_O,
    output logic                      PSLVERR_O,
    // Table entries held outside this block
    input  wire logic [41:0]          EXT_PHYS_ADDR_I,
    input  wire logic [27:0]          EXT_ALIAS_I,
    // Local controller address request
    input  wire logic                 REQ_VALID_I,
    input  wire rar_pkg::rar_addr_t   REQ_ADDR_I,
    input  wire logic                 REQ_RNW_I,
    // Forward request toward the control channel
    output logic                      FWD_VALID_O,
    output rar_pkg::rar_addr_t        FWD_ADDR_O,
    output logic                      FWD_RNW_O,
    output rar_pkg::rar_slot_t        FWD_SLOT_O,
    // Request not handled by the remap table
    output logic                      NOMATCH_O
);
    import rar_pkg::*;

    // =================================================================
    // Local slot registers
    rar_addr_t phys_6_ff;
    rar_addr_t phys_7_ff;
    rar_addr_t alias_ff [0:3];

    // =================================================================
    // APB decode
    wire setup_phase  = PSEL_I && !PENABLE_I;
    wire access_phase = PSEL_I && PENABLE_I;
    wire wr_en        = access_phase && PWRITE_I;

    wire sel_phys_6   = (PADDR_I == `RAR_ADDR_PHYS_6);
    wire sel_phys_7   = (PADDR_I == `RAR_ADDR_PHYS_7);
    wire sel_alias_0  = (PADDR_I == `RAR_ADDR_ALIAS_0);
    wire sel_alias_1  = (PADDR_I == `RAR_ADDR_ALIAS_1);
    wire sel_alias_2  = (PADDR_I == `RAR_ADDR_ALIAS_2);
    wire sel_alias_3  = (PADDR_I == `RAR_ADDR_ALIAS_3);
    wire sel_status   = (PADDR_I == `RAR_ADDR_STATUS);
    wire sel_any      = sel_phys_6 || sel_phys_7 || sel_alias_0 || sel_alias_1
                        || sel_alias_2 || sel_alias_3 || sel_status;
    // Status is read only; a write to it is an error too
    wire bad_access   = !sel_any || (PWRITE_I && sel_status);

    wire [3:0] sel_alias = {sel_alias_3, sel_alias_2, sel_alias_1, sel_alias_0};

    // Bit 0 of a slot register is reserved: written value is dropped
    wire rar_addr_t wr_field = PWDATA_I[`RAR_FLD_ADDR_HI:`RAR_FLD_ADDR_LO];

    // =================================================================
    // Slot register writes
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            phys_6_ff <= `RAR_SLOT_RESET;
            phys_7_ff <= `RAR_SLOT_RESET;
        end else if (wr_en) begin
            if (sel_phys_6) begin
                phys_6_ff <= wr_field;   // [R1]
            end
            if (sel_phys_7) begin
                phys_7_ff <= wr_field;   // [R1]
            end
        end
    end

    genvar ga;
    generate
        for (ga = 0; ga < 4; ga++) begin : g_alias_reg
            always_ff @(posedge REF_CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    alias_ff[ga] <= `RAR_SLOT_RESET;
                end else if (wr_en && sel_alias[ga]) begin
                    alias_ff[ga] <= wr_field;   // [R3]
                end
            end
        end
    endgenerate

    // =================================================================
    // Full eight-entry table, local and outside entries merged
    rar_addr_t tbl_phys  [0:7];
    rar_addr_t tbl_alias [0:7];

    genvar gt;
    generate
        for (gt = 0; gt < `RAR_NUM_EXT_PHYS; gt++) begin : g_ext_phys
            assign tbl_phys[gt] = EXT_PHYS_ADDR_I[gt*7 +: 7];
        end
        for (gt = 0; gt < `RAR_NUM_EXT_ALIAS; gt++) begin : g_ext_alias
            assign tbl_alias[gt + `RAR_FIRST_EXT_ALIAS] = EXT_ALIAS_I[gt*7 +: 7];
            assign tbl_alias[gt]                        = alias_ff[gt];
        end
    endgenerate

    assign tbl_phys[`RAR_FIRST_LOC_PHYS]     = phys_6_ff;
    assign tbl_phys[`RAR_FIRST_LOC_PHYS + 1] = phys_7_ff;

    // =================================================================
    // Alias decoder, one comparator per slot
    logic [7:0] slot_hit;

    genvar gm;
    generate
        for (gm = 0; gm < `RAR_NUM_SLOTS; gm++) begin : g_match
            rar_slot_match u_match (
                .alias_i    (tbl_alias[gm]),   // [R5] [R6]
                .req_addr_i (REQ_ADDR_I),
                .hit_o      (slot_hit[gm])
            );
        end
    endgenerate

    // Lowest slot wins when two aliases are programmed alike
    rar_slot_t hit_slot;
    logic      any_hit;

    always_comb begin
        hit_slot = 3'd0;
        any_hit  = 1'b0;
        for (int i = `RAR_NUM_SLOTS - 1; i >= 0; i--) begin
            if (slot_hit[i]) begin
                hit_slot = 3'(i);
                any_hit  = 1'b1;
            end
        end
    end

    // Same index on both sides of the table
    wire rar_addr_t remap_addr = tbl_phys[hit_slot];   // [R4]

    // =================================================================
    // Forward request registers
    logic      fwd_valid_ff;
    rar_addr_t fwd_addr_ff;
    logic      fwd_rnw_ff;
    rar_slot_t fwd_slot_ff;
    logic      nomatch_ff;

    wire nxt_fwd_valid = REQ_VALID_I && any_hit;    // [R2] [R7]
    wire nxt_nomatch   = REQ_VALID_I && !any_hit;   // [R7]

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fwd_valid_ff <= 1'b0;
            nomatch_ff   <= 1'b0;
        end else begin
            fwd_valid_ff <= nxt_fwd_valid;
            nomatch_ff   <= nxt_nomatch;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fwd_addr_ff <= `RAR_SLOT_RESET;
            fwd_rnw_ff  <= 1'b0;
            fwd_slot_ff <= 3'd0;
        end else if (nxt_fwd_valid) begin
            fwd_addr_ff <= remap_addr;   // [R2] [R4]
            fwd_rnw_ff  <= REQ_RNW_I;
            fwd_slot_ff <= hit_slot;
        end
    end

    // =================================================================
    // Status: outcome of the latest request
    logic      st_valid_ff;
    logic      st_hit_ff;
    rar_slot_t st_slot_ff;
    rar_addr_t st_phys_ff;
    rar_addr_t st_req_ff;

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_valid_ff <= 1'b0;
            st_hit_ff   <= 1'b0;
            st_slot_ff  <= 3'd0;
            st_phys_ff  <= `RAR_SLOT_RESET;
            st_req_ff   <= `RAR_SLOT_RESET;
        end else if (REQ_VALID_I) begin
            st_valid_ff <= 1'b1;
            st_hit_ff   <= any_hit;
            st_slot_ff  <= any_hit ? hit_slot : 3'd0;
            st_phys_ff  <= any_hit ? remap_addr : `RAR_SLOT_RESET;   // [R7]
            st_req_ff   <= REQ_ADDR_I;
        end
    end

    rar_word_t status_word;

    always_comb begin
        status_word                                 = `RAR_ZERO_WORD;
        status_word[`RAR_ST_HIT]                    = st_hit_ff;
        status_word[`RAR_ST_SLOT_HI:`RAR_ST_SLOT_LO] = st_slot_ff;
        status_word[`RAR_ST_PHYS_HI:`RAR_ST_PHYS_LO] = st_phys_ff;
        status_word[`RAR_ST_REQ_HI:`RAR_ST_REQ_LO]   = st_req_ff;
        status_word[`RAR_ST_VALID]                  = st_valid_ff;
    end

    // =================================================================
    // Read mux: slot field back in bits 7:1, reserved bit reads zero
    function automatic rar_word_t slot_word(input rar_addr_t a);
        rar_word_t w;
        w                                          = `RAR_ZERO_WORD;
        w[`RAR_FLD_ADDR_HI:`RAR_FLD_ADDR_LO]       = a;
        return w;
    endfunction

    wire rar_word_t rd_mux =
        sel_phys_6  ? slot_word(phys_6_ff)   :
        sel_phys_7  ? slot_word(phys_7_ff)   :
        sel_alias_0 ? slot_word(alias_ff[0]) :
        sel_alias_1 ? slot_word(alias_ff[1]) :
        sel_alias_2 ? slot_word(alias_ff[2]) :
        sel_alias_3 ? slot_word(alias_ff[3]) :
        sel_status  ? status_word            :
                      `RAR_ZERO_WORD;

    // Read data and error are captured in the setup cycle
    rar_word_t prdata_ff;
    logic      pslverr_ff;

    wire rar_word_t nxt_prdata  = PWRITE_I ? `RAR_ZERO_WORD : rd_mux;
    wire            nxt_pslverr = bad_access;

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            prdata_ff  <= `RAR_ZERO_WORD;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // =================================================================
    // Outputs
    assign PREADY_O    = 1'b1;
    assign PRDATA_O    = prdata_ff;
    assign PSLVERR_O   = access_phase && pslverr_ff;
    assign FWD_VALID_O = fwd_valid_ff;
    assign FWD_ADDR_O  = fwd_addr_ff;
    assign FWD_RNW_O   = fwd_rnw_ff;
    assign FWD_SLOT_O  = fwd_slot_ff;
    assign NOMATCH_O   = nomatch_ff;
endmodule

`default_nettype wire

//--- inc/rar_defs.svh
`ifndef RAR_DEFS_SVH
`define RAR_DEFS_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define RAR_IDX_PHYS_6      8'h0E
`define RAR_IDX_PHYS_7      8'h0F
`define RAR_IDX_ALIAS_0     8'h10
`define RAR_IDX_ALIAS_1     8'h11
`define RAR_IDX_ALIAS_2     8'h12
`define RAR_IDX_ALIAS_3     8'h13
`define RAR_IDX_STATUS      8'h20

// =====================================================================
// Byte addresses on the register bus
`define RAR_ADDR_PHYS_6     8'(`RAR_IDX_PHYS_6 * 4)
`define RAR_ADDR_PHYS_7     8'(`RAR_IDX_PHYS_7 * 4)
`define RAR_ADDR_ALIAS_0    8'(`RAR_IDX_ALIAS_0 * 4)
`define RAR_ADDR_ALIAS_1    8'(`RAR_IDX_ALIAS_1 * 4)
`define RAR_ADDR_ALIAS_2    8'(`RAR_IDX_ALIAS_2 * 4)
`define RAR_ADDR_ALIAS_3    8'(`RAR_IDX_ALIAS_3 * 4)
`define RAR_ADDR_STATUS     8'(`RAR_IDX_STATUS * 4)

// =====================================================================
// Address field of every slot register: bits 7 down to 1
`define RAR_FLD_ADDR_HI     7
`define RAR_FLD_ADDR_LO     1
`define RAR_SLOT_RESET      7'h00
`define RAR_ALIAS_OFF       7'h00

// =====================================================================
// Status register layout
`define RAR_ST_HIT          0
`define RAR_ST_SLOT_LO      1
`define RAR_ST_SLOT_HI      3
`define RAR_ST_PHYS_LO      4
`define RAR_ST_PHYS_HI      10
`define RAR_ST_REQ_LO       11
`define RAR_ST_REQ_HI       17
`define RAR_ST_VALID        18

// =====================================================================
// Table geometry
`define RAR_NUM_SLOTS       8
`define RAR_NUM_EXT_PHYS    6
`define RAR_NUM_EXT_ALIAS   4
`define RAR_FIRST_LOC_PHYS  6
`define RAR_FIRST_EXT_ALIAS 4
`define RAR_ZERO_WORD       32'h0000_0000

`endif

//--- inc/rar_pkg.sv
package rar_pkg;
    typedef logic [6:0]  rar_addr_t;
    typedef logic [2:0]  rar_slot_t;
    typedef logic [31:0] rar_word_t;
    typedef logic [7:0]  rar_paddr_t;
endpackage

//--- design/rar_slot_match.sv
`timescale 1ns/1ns
`default_nettype none
`include "rar_defs.svh"

// =====================================================================
// One alias comparator; a zero alias never matches
module rar_slot_match
    import rar_pkg::*;
(
    // Slot contents
    input  wire rar_pkg::rar_addr_t alias_i,
    // Request address
    input  wire rar_pkg::rar_addr_t req_addr_i,
    // Result
    output logic                    hit_o
);
    wire armed = (alias_i != `RAR_ALIAS_OFF);

    assign hit_o = armed && (alias_i == req_addr_i);
endmodule

`default_nettype wire

//--- verif/rar_alias_remap_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Forward path checks
module rar_alias_remap_props
    import rar_pkg::*;
(
    // Clock and reset
    input wire logic               REF_CLK_I,
    input wire logic               RST_I,
    // Table and request
    input wire logic [41:0]        EXT_PHYS_ADDR_I,
    input wire logic [27:0]        EXT_ALIAS_I,
    input wire logic               REQ_VALID_I,
    input wire rar_pkg::rar_addr_t REQ_ADDR_I,
    input wire logic               REQ_RNW_I,
    // Forward result
    input wire logic               FWD_VALID_O,
    input wire rar_pkg::rar_addr_t FWD_ADDR_O,
    input wire logic               FWD_RNW_O,
    input wire rar_pkg::rar_slot_t FWD_SLOT_O,
    input wire logic               NOMATCH_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    one_answer_a: assert property (REQ_VALID_I |=> FWD_VALID_O != NOMATCH_O)
        else $error("no single answer");
    quiet_idle_a: assert property (!REQ_VALID_I |=> !FWD_VALID_O && !NOMATCH_O)
        else $error("answer without request");
    zero_miss_a: assert property (REQ_VALID_I && REQ_ADDR_I == 7'h00 |=> NOMATCH_O)
        else $error("zero address matched");
    ext_hit_a: assert property (REQ_VALID_I && REQ_ADDR_I != 7'h00
        && REQ_ADDR_I == EXT_ALIAS_I[6:0] |=> FWD_VALID_O && FWD_SLOT_O <= 3'h4)
        else $error("armed slot missed");
    ext_phys_a: assert property (FWD_VALID_O && FWD_SLOT_O < 3'h6
        |-> FWD_ADDR_O == 7'($past(EXT_PHYS_ADDR_I) >> (7 * FWD_SLOT_O)))
        else $error("wrong physical address");
    rnw_copy_a: assert property (REQ_VALID_I ##1 FWD_VALID_O
        |-> FWD_RNW_O == $past(REQ_RNW_I)) else $error("direction lost");
    addr_hold_a: assert property (!FWD_VALID_O |-> $stable(FWD_ADDR_O))
        else $error("address moved");
    slot_hold_a: assert property (!FWD_VALID_O |-> $stable(FWD_SLOT_O))
        else $error("slot moved");
    cover property (FWD_VALID_O && FWD_SLOT_O == 3'h6);
    cover property (REQ_VALID_I && REQ_ADDR_I == 7'h00);
    cover property (NOMATCH_O);
endmodule
bind rar_alias_remap rar_alias_remap_props u_props (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
    .EXT_PHYS_ADDR_I(EXT_PHYS_ADDR_I), .EXT_ALIAS_I(EXT_ALIAS_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_ADDR_I(REQ_ADDR_I), .REQ_RNW_I(REQ_RNW_I), .FWD_VALID_O(FWD_VALID_O),
    .FWD_ADDR_O(FWD_ADDR_O), .FWD_RNW_O(FWD_RNW_O), .FWD_SLOT_O(FWD_SLOT_O),
    .NOMATCH_O(NOMATCH_O));
`default_nettype wire

//--- verif/rar_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Local controller: one address request per call
module rar_ctl_model
    import rar_pkg::*;
(
    input  wire logic         clk_i,
    output logic              req_valid_o,
    output rar_pkg::rar_addr_t req_addr_o,
    output logic              req_rnw_o
);
    initial begin
        req_valid_o = 1'b0;
        req_addr_o = 7'h00;
        req_rnw_o = 1'b0;
    end
    task automatic send(input rar_addr_t a, input logic r);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_addr_o <= a;
        req_rnw_o <= r;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        // Released lines show junk
        req_addr_o <= ~a;
        req_rnw_o <= ~r;
    endtask
endmodule
`default_nettype wire

//--- verif/rar_alias_remap_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "rar_defs.svh"
module rar_alias_remap_tb;
    import rar_pkg::*;
    logic       clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic       fwd_v, fwd_rnw, nomatch, req_v, req_rnw;
    rar_paddr_t paddr;
    rar_word_t  pwdata, prdata, rdata, d;
    rar_addr_t  req_a, fwd_a, al[8], ph[8], last_a;
    rar_slot_t  fwd_s;
    logic [41:0] ext_phys;
    logic [27:0] ext_alias;
    logic [63:0] w;
    logic [11:0] e, expq[$], last_v;
    int         fail_count, checks, seed;
    rar_paddr_t regs[6] = '{`RAR_ADDR_PHYS_6, `RAR_ADDR_PHYS_7, `RAR_ADDR_ALIAS_0,
                            `RAR_ADDR_ALIAS_1, `RAR_ADDR_ALIAS_2, `RAR_ADDR_ALIAS_3};
    rar_alias_remap dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .EXT_PHYS_ADDR_I(ext_phys),
        .EXT_ALIAS_I(ext_alias), .REQ_VALID_I(req_v), .REQ_ADDR_I(req_a), .REQ_RNW_I(req_rnw),
        .FWD_VALID_O(fwd_v), .FWD_ADDR_O(fwd_a), .FWD_RNW_O(fwd_rnw), .FWD_SLOT_O(fwd_s),
        .NOMATCH_O(nomatch));
    rar_ctl_model ctl (.clk_i(clk), .req_valid_o(req_v), .req_addr_o(req_a),
        .req_rnw_o(req_rnw));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input rar_paddr_t a, input rar_word_t v);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("mismatch at %0t: no ready from slave", $time);
            fail_count++;
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reset_chk();
        for (int j = 0; j < 6; j++) begin
            apb(1'b0, regs[j], 32'h0000_0000);
            chk(rdata, 32'h0000_0000);
        end
        apb(1'b0, `RAR_ADDR_STATUS, 32'h0000_0000);
        chk({err, rdata}, {1'b0, 32'h0000_0000});
    endtask
    function automatic logic [11:0] expect_of(input rar_addr_t a, input logic r);
        logic [11:0] v;
        v = 12'h000;
        for (int i = 7; i >= 0; i--) if (al[i] != 7'h00 && al[i] == a) v = {1'b1, 3'(i), ph[i], r};
        return v;
    endfunction
    task automatic reqs(input int n);
        logic [31:0] r;
        rar_addr_t a;
        repeat (n) begin
            r = $random(seed);
            a = r[3] ? al[r[6:4]] : r[13:7];
            if (r[2:0] == 3'h0) a = 7'h00;
            last_a = a;
            last_v = expect_of(a, r[20]);
            expq.push_back(last_v);
            ctl.send(a, r[20]);
        end
    endtask
    // ==========
    // Answer monitor
    always @(posedge clk) if (fwd_v === 1'b1 || nomatch === 1'b1) begin
        e = expq.size() > 0 ? expq.pop_front() : 12'hFFF;
        chk({fwd_v, nomatch, fwd_v ? {fwd_s, fwd_a, fwd_rnw} : 11'h000},
            {e[11], ~e[11], e[10:0]});
    end
    initial begin
        #50000;
        fail_count++;
        close_out();
    end
    initial begin
        seed = 87156;
        fail_count = 0;
        checks = 0;
        {rst, psel, penable, pwrite, paddr, pwdata, ext_phys, ext_alias} = '1;
        {psel, penable} = 2'b00;
        for (int i = 0; i < 8; i++) {al[i], ph[i]} = 14'h0000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        reset_chk();
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk({err, rdata}, {1'b1, 32'h0000_0000});
        apb(1'b1, `RAR_ADDR_STATUS, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        w = {$random(seed), $random(seed)};
        ext_phys <= w[41:0];
        ext_alias <= w[63:36];
        for (int k = 0; k < 6; k++) ph[k] = w[7*k +: 7];
        for (int k = 0; k < 4; k++) al[4+k] = w[36+7*k +: 7];
        for (int j = 0; j < 6; j++) begin
            d = $random(seed);
            if (j == 3) d[7:1] = 7'h00;
            if (j == 5) d[7:1] = w[42:36];
            apb(1'b1, regs[j], d);
            apb(1'b0, regs[j], 32'h0000_0000);
            chk({err, rdata}, {1'b0, 24'h00_0000, d[7:1], 1'b0});
            if (j < 2) ph[6+j] = d[7:1];
            else al[j-2] = d[7:1];
        end
        reqs(64);
        apb(1'b0, `RAR_ADDR_STATUS, 32'h0000_0000);
        chk(rdata, {13'h0000, 1'b1, last_a, last_v[7:1], last_v[10:8], last_v[11]});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) al[i] = 7'h00;
        {ph[6], ph[7]} = 14'h0000;
        reset_chk();
        reqs(24);
        repeat (4) @(posedge clk);
        chk(32'(expq.size()), 32'h0000_0000);
        close_out();
    end
endmodule
`default_nettype wire
